//--- hw/irq_params.svh
// register offsets, field positions and reset values of the interrupt unit
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH
`define OFS_EDGE_SEL 4'h0
`define OFS_CTRL_ZERO 4'h4
`define OFS_CTRL_ONE 4'h8
`define OFS_SHARED_SRC 4'hC
`define OFS_STATUS 5'h10
`define CTRL_RESET 8'h00
`define C0_GLOBAL_EN 0
`define C0_PIN_A_EN 1
`define C0_PIN_B_EN 2
`define C0_TMR0_EN 3
`define C0_PIN_A_FLAG 4
`define C0_PIN_B_FLAG 5
`define C0_TMR0_FLAG 6
`define C1_TMR1_EN 0
`define C1_TMR2_EN 1
`define C1_SHARED_EN 2
`define C1_TMR1_FLAG 4
`define C1_TMR2_FLAG 5
`define C1_SHARED_FLAG 6
`define C0_MASK 8'h7F
`define C1_MASK 8'h77
`define EDGE_MASK 8'h0F
`define SRC_MASK 8'h77
`define VEC_PIN_A 8'h04
`define VEC_PIN_B 8'h08
`define VEC_TMR0 8'h0C
`define VEC_TMR1 8'h10
`define VEC_TMR2 8'h14
`define VEC_SHARED 8'h18
`endif

//--- hw/irq_pkg.sv
// types shared by the interrupt unit
package irq_pkg;
  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_mode_e;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRESP = 2'b01,
    BUS_RDATA = 2'b10
  } bus_state_e;
endpackage : irq_pkg

//--- hw/pin_edge_detect.sv
// synchroniser and selectable edge detector for one external pin
`timescale 1ns/1ns
module pin_edge_detect
  import irq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pin,
  input wire logic [1:0] mode,
  output logic hit
);
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic hit_d;

  always_comb begin
    sync_d = {sync_q[1:0], pin};
    case (edge_mode_e'(mode))
      EDGE_RISE: hit_d = sync_q[1] & ~sync_q[2];
      EDGE_FALL: hit_d = ~sync_q[1] & sync_q[2];
      EDGE_BOTH: hit_d = sync_q[1] ^ sync_q[2];
      default: hit_d = 1'b0;
    endcase
  end

  // first stage is read only by the second one
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_q <= 3'h0;
      hit <= 1'b0;
    end else begin
      sync_q <= sync_d;
      hit <= hit_d;
    end
  end

  a_single_hit: assert property (@(posedge core_clk)
    disable iff (!rst_b) hit |=> !hit)
    else $error("edge hit lasted two cycles");
endmodule : pin_edge_detect

//--- hw/vectored_interrupt_unit.sv
// vectored interrupt controller with AXI4-Lite register access
// Function
// - event inputs and selected pin edges set their request flags.
// - enabled pending flag pushes PC and loads that source's vector.
// - return strobe pops the saved PC so execution resumes.
// - entering service clears the global enable.
// - requests arriving while blocked stay latched for later service.
// - no request is acknowledged while the return stack is full.
// - requests between two phase pulses are serviced on the later one.
// - fixed priority pin A, pin B, timer 0, 1, 2, shared source.
// - conversion and two time bases keep own flags, share one flag.
// - service clears shared flag only; software clears source flags.
// - global enable zero means no service at all.
// - two-bit edge select per pin: off, rising, falling, both.
// - edge register upper nibble reads zero; selects reset to zero.
// - control zero holds global, pin and timer 0 enables and flags.
// - control one holds timer 1, 2, shared enables and flags.
// - shared flag sets on a time base or conversion request whose source enable is set.
// - conversion interrupt needs global, own and shared enables.
// - control one bit 0 enables timer 1 requests.
`timescale 1ns/1ns
`include "irq_params.svh"
module vectored_interrupt_unit
  import irq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic [2:0] timer_overflow,
  input wire logic [1:0] time_base_overflow,
  input wire logic conversion_done,
  input wire logic second_phase_pulse,
  input wire logic stack_full,
  input wire logic return_strobe,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_take,
  output logic [7:0] irq_vector,
  output logic pc_push,
  output logic pc_pop
);
  logic [7:0] edge_q, edge_d;
  logic [7:0] c0_q, c0_d;
  logic [7:0] c1_q, c1_d;
  logic [7:0] src_q, src_d;
  logic pin_a_hit, pin_b_hit;
  logic take_d, push_d, pop_d;
  logic [7:0] vec_d;
  bus_state_e bus_q, bus_d;
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [4:0] waddr_q, waddr_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic wen_q, wen_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic wbyte_mask_q, wbyte_mask_d;
  logic [5:0] pend;

  function automatic logic mapped(input logic [4:0] a);
    mapped = (a == 5'(`OFS_EDGE_SEL)) || (a == 5'(`OFS_CTRL_ZERO)) ||
             (a == 5'(`OFS_CTRL_ONE)) || (a == 5'(`OFS_SHARED_SRC)) ||
             (a == `OFS_STATUS);
  endfunction : mapped

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] val,
                                       input logic [4:0] a,
                                       input logic [4:0] ofs,
                                       input logic [7:0] msk);
    merge = (wen_q && a == ofs) ? (val & msk) : old;
  endfunction : merge

  pin_edge_detect pin_a_det (
    .core_clk(core_clk), .rst_b(rst_b), .pin(ext_irq_pin_a),
    .mode(edge_q[1:0]), .hit(pin_a_hit)
  );
  pin_edge_detect pin_b_det (
    .core_clk(core_clk), .rst_b(rst_b), .pin(ext_irq_pin_b),
    .mode(edge_q[3:2]), .hit(pin_b_hit)
  );

  // enabled pending sources, priority order low index first
  always_comb begin
    pend[0] = c0_q[`C0_PIN_A_FLAG] & c0_q[`C0_PIN_A_EN];
    pend[1] = c0_q[`C0_PIN_B_FLAG] & c0_q[`C0_PIN_B_EN];
    pend[2] = c0_q[`C0_TMR0_FLAG] & c0_q[`C0_TMR0_EN];
    pend[3] = c1_q[`C1_TMR1_FLAG] & c1_q[`C1_TMR1_EN];
    pend[4] = c1_q[`C1_TMR2_FLAG] & c1_q[`C1_TMR2_EN];
    pend[5] = c1_q[`C1_SHARED_FLAG] & c1_q[`C1_SHARED_EN];
  end

  // register and flag next state
  always_comb begin
    edge_d = merge(edge_q, wbyte_q, waddr_q, 5'(`OFS_EDGE_SEL), `EDGE_MASK);
    c0_d = merge(c0_q, wbyte_q, waddr_q, 5'(`OFS_CTRL_ZERO), `C0_MASK);
    c1_d = merge(c1_q, wbyte_q, waddr_q, 5'(`OFS_CTRL_ONE), `C1_MASK);
    src_d = merge(src_q, wbyte_q, waddr_q, 5'(`OFS_SHARED_SRC), `SRC_MASK);
    // direct flag writes above; hardware sets below win
    take_d = 1'b0;
    vec_d = irq_vector;
    // sample on phase pulse; flags keep pending across blocked time
    if (second_phase_pulse && c0_q[`C0_GLOBAL_EN] && !stack_full &&
        (pend != 6'h00)) begin
      take_d = 1'b1;
      c0_d[`C0_GLOBAL_EN] = 1'b0;
      if (pend[0]) begin
        vec_d = `VEC_PIN_A;
        c0_d[`C0_PIN_A_FLAG] = 1'b0;
      end else if (pend[1]) begin
        vec_d = `VEC_PIN_B;
        c0_d[`C0_PIN_B_FLAG] = 1'b0;
      end else if (pend[2]) begin
        vec_d = `VEC_TMR0;
        c0_d[`C0_TMR0_FLAG] = 1'b0;
      end else if (pend[3]) begin
        vec_d = `VEC_TMR1;
        c1_d[`C1_TMR1_FLAG] = 1'b0;
      end else if (pend[4]) begin
        vec_d = `VEC_TMR2;
        c1_d[`C1_TMR2_FLAG] = 1'b0;
      end else begin
        vec_d = `VEC_SHARED;
        c1_d[`C1_SHARED_FLAG] = 1'b0;
      end
    end
    if (pin_a_hit) c0_d[`C0_PIN_A_FLAG] = 1'b1;
    if (pin_b_hit) c0_d[`C0_PIN_B_FLAG] = 1'b1;
    if (timer_overflow[0]) c0_d[`C0_TMR0_FLAG] = 1'b1;
    if (timer_overflow[1]) c1_d[`C1_TMR1_FLAG] = 1'b1;
    if (timer_overflow[2]) c1_d[`C1_TMR2_FLAG] = 1'b1;
    if (conversion_done) src_d[4] = 1'b1;
    if (time_base_overflow[0]) src_d[5] = 1'b1;
    if (time_base_overflow[1]) src_d[6] = 1'b1;
    // conversion counts only with its own enable
    if ((conversion_done && src_q[0]) ||
        (time_base_overflow[0] && src_q[1]) ||
        (time_base_overflow[1] && src_q[2]))
      c1_d[`C1_SHARED_FLAG] = 1'b1;
    push_d = take_d;
    pop_d = return_strobe;
  end

  // AXI4-Lite slave: address and data taken in either order
  always_comb begin
    bus_d = bus_q;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    waddr_d = waddr_q;
    wbyte_d = wbyte_q;
    wen_d = 1'b0;
    awready_d = 1'b0;
    wready_d = 1'b0;
    bvalid_d = s_axi_bvalid;
    bresp_d = s_axi_bresp;
    arready_d = 1'b0;
    rvalid_d = s_axi_rvalid;
    rresp_d = s_axi_rresp;
    rdata_d = s_axi_rdata;
    wbyte_mask_d = wbyte_mask_q;
    case (bus_q)
      BUS_IDLE: begin
        if (s_axi_arvalid && !s_axi_arready) begin
          arready_d = 1'b1;
          bus_d = BUS_RDATA;
          rvalid_d = 1'b1;
          rresp_d = mapped(s_axi_araddr[4:0]) && s_axi_araddr[31:5] == 27'h0
                    ? 2'b00 : 2'b10;
          case (s_axi_araddr[4:0])
            5'(`OFS_EDGE_SEL): rdata_d = {24'h0, edge_q};
            5'(`OFS_CTRL_ZERO): rdata_d = {24'h0, c0_q};
            5'(`OFS_CTRL_ONE): rdata_d = {24'h0, c1_q};
            5'(`OFS_SHARED_SRC): rdata_d = {24'h0, src_q};
            `OFS_STATUS: rdata_d = {23'h0, stack_full, irq_vector};
            default: rdata_d = 32'h0;
          endcase
        end else begin
          if (s_axi_awvalid && !aw_got_q && !s_axi_awready) begin
            awready_d = 1'b1;
            aw_got_d = 1'b1;
            waddr_d = s_axi_awaddr[4:0];
          end
          if (s_axi_wvalid && !w_got_q && !s_axi_wready) begin
            wready_d = 1'b1;
            w_got_d = 1'b1;
            wbyte_d = s_axi_wdata[7:0];
            wbyte_mask_d = s_axi_wstrb[0];
          end
          if (aw_got_q && w_got_q) begin
            wen_d = mapped(waddr_q) && wbyte_mask_q;
            bvalid_d = 1'b1;
            bresp_d = mapped(waddr_q) ? 2'b00 : 2'b10;
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bus_d = BUS_WRESP;
          end
        end
      end
      BUS_WRESP: if (s_axi_bready) begin
        bvalid_d = 1'b0;
        bus_d = BUS_IDLE;
      end
      BUS_RDATA: if (s_axi_rready) begin
        rvalid_d = 1'b0;
        bus_d = BUS_IDLE;
      end
      default: bus_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_q <= `CTRL_RESET;
      c0_q <= `CTRL_RESET;
      c1_q <= `CTRL_RESET;
      src_q <= `CTRL_RESET;
      bus_q <= BUS_IDLE;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      waddr_q <= 5'h00;
      wbyte_q <= 8'h00;
      wbyte_mask_q <= 1'b0;
      wen_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0;
      irq_take <= 1'b0;
      irq_vector <= 8'h00;
      pc_push <= 1'b0;
      pc_pop <= 1'b0;
    end else begin
      edge_q <= edge_d;
      c0_q <= c0_d;
      c1_q <= c1_d;
      src_q <= src_d;
      bus_q <= bus_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      waddr_q <= waddr_d;
      wbyte_q <= wbyte_d;
      wbyte_mask_q <= wbyte_mask_d;
      wen_q <= wen_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rresp <= rresp_d;
      s_axi_rdata <= rdata_d;
      irq_take <= take_d;
      irq_vector <= vec_d;
      pc_push <= push_d;
      pc_pop <= pop_d;
    end
  end

  sequence s_taken;
    irq_take;
  endsequence

  // service clear is applied after the write merge, so no write can save it
  a_take_clears_global: assert property (@(posedge core_clk)
    disable iff (!rst_b) s_taken |-> !c0_q[`C0_GLOBAL_EN])
    else $error("global enable not cleared on entry");
  a_no_take_blocked: assert property (@(posedge core_clk)
    disable iff (!rst_b) (!second_phase_pulse || !c0_q[`C0_GLOBAL_EN] ||
    stack_full) |=> !irq_take)
    else $error("service outside allowed moment");
  a_take_when_ready: assert property (@(posedge core_clk)
    disable iff (!rst_b) (second_phase_pulse && c0_q[`C0_GLOBAL_EN] &&
    !stack_full && pend != 6'h00) |=> irq_take)
    else $error("pending request not serviced");
  a_pin_a_first: assert property (@(posedge core_clk)
    disable iff (!rst_b) (second_phase_pulse && c0_q[`C0_GLOBAL_EN] &&
    !stack_full && pend[0]) |=> irq_vector == `VEC_PIN_A)
    else $error("priority vector wrong");
  a_shared_vector: assert property (@(posedge core_clk)
    disable iff (!rst_b) (second_phase_pulse && c0_q[`C0_GLOBAL_EN] &&
    !stack_full && pend == 6'h20) |=> irq_vector == `VEC_SHARED)
    else $error("shared vector wrong");
  a_push_with_take: assert property (@(posedge core_clk)
    disable iff (!rst_b) (pc_push == irq_take) &&
    (!pc_push || ($past(second_phase_pulse) && !$past(stack_full))))
    else $error("push not paired with take");
  a_pop_follows: assert property (@(posedge core_clk)
    disable iff (!rst_b) return_strobe |=> pc_pop)
    else $error("return did not pop");
  a_event_latched: assert property (@(posedge core_clk)
    disable iff (!rst_b) timer_overflow[1] |=> c1_q[`C1_TMR1_FLAG])
    else $error("timer flag lost");
  a_edge_upper_zero: assert property (@(posedge core_clk)
    disable iff (!rst_b) edge_q[7:4] == 4'h0)
    else $error("edge upper bits set");
endmodule : vectored_interrupt_unit

//--- test/cpu_core_model.sv
// behavioural model of the cpu core: phase pulse, return stack, returns
`timescale 1ns/1ns
module cpu_core_model #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pc_push,
  input wire logic pc_pop,
  input wire logic do_return,
  output logic second_phase_pulse,
  output logic stack_full,
  output logic return_strobe
);
  logic [1:0] phase_q;
  int depth_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= 2'h0;
      depth_q <= 0;
      return_strobe <= 1'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
      // an empty stack is never popped below zero, as on the real core
      if (pc_push && !pc_pop) begin
        depth_q <= depth_q + 1;
      end else if (pc_pop && !pc_push && depth_q > 0) begin
        depth_q <= depth_q - 1;
      end
      return_strobe <= do_return;
    end
  end

  // one sampling pulse in four cycles, so requests gather between pulses
  assign second_phase_pulse = (phase_q == 2'h3);
  assign stack_full = (depth_q >= STACK_DEPTH);
endmodule : cpu_core_model

//--- test/vectored_interrupt_unit_bench.sv
// self-checking bench for the vectored interrupt unit
`timescale 1ns/1ns
module vectored_interrupt_unit_bench
  import irq_pkg::*;
;
  logic core_clk = 1'h0;
  logic rst_b = 1'h0;
  logic ext_irq_pin_a = 1'h0;
  logic ext_irq_pin_b = 1'h1;
  logic [2:0] timer_overflow = 3'h0;
  logic [1:0] time_base_overflow = 2'h0;
  logic conversion_done = 1'h0;
  logic do_return = 1'h0;
  logic second_phase_pulse, stack_full, return_strobe;
  logic irq_take, pc_push, pc_pop;
  logic [7:0] irq_vector;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] exp_rd[$];
  logic [8:0] exp_irq[$];
  int fails = 0;
  int checks_done = 0;
  logic [7:0] c0_exp;
  logic [31:0] rnd;

  vectored_interrupt_unit u_vectored_interrupt_unit (.core_clk, .rst_b,
    .ext_irq_pin_a, .ext_irq_pin_b, .timer_overflow, .time_base_overflow,
    .conversion_done, .second_phase_pulse, .stack_full, .return_strobe,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_take,
    .irq_vector, .pc_push, .pc_pop);

  // a shallow stack lets the full-stack case be reached quickly
  cpu_core_model #(.STACK_DEPTH(6)) u_cpu_core_model (.core_clk, .rst_b,
    .pc_push, .pc_pop, .do_return, .second_phase_pulse, .stack_full,
    .return_strobe);

  always #25 core_clk = ~core_clk;

  task automatic check(input string what, input logic [33:0] e,
                       input logic [33:0] s);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, e, s);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  // results are judged here, against the oldest note left by the drivers
  always @(posedge core_clk) begin
    if (s_axi_rvalid === 1'h1 && s_axi_rready) begin
      check("read", exp_rd.size() != 0 ? exp_rd.pop_front() : 'x,
            {s_axi_rresp, s_axi_rdata});
    end
    if (irq_take !== 1'h0) begin
      check("vector", exp_irq.size() != 0 ? exp_irq.pop_front() : 'x,
            {pc_push, irq_vector});
    end
  end

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    // one edge between transfers so no strobe is assigned twice at once
    @(posedge core_clk);
    aw_ok = 1'h0;
    w_ok = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (!aw_ok && s_axi_awready === 1'h1) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_ok && s_axi_wready === 1'h1) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'h1);
    check("bresp", 34'h0, {32'h0, s_axi_bresp});
    s_axi_bready <= 1'h0;
  endtask : axi_wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    @(posedge core_clk);
    exp_rd.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge core_clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) @(posedge core_clk);
    s_axi_rready <= 1'h0;
  endtask : rd_chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  task automatic drain();
    int n;
    n = 0;
    while (exp_irq.size() != 0 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    check("pending services", 34'h0, 34'(exp_irq.size()));
  endtask : drain

  initial begin
    rnd = $urandom(32'h9239);
    tick(12);
    rst_b <= 1'h1;
    @(posedge core_clk);
    rd_chk(32'h0, 32'h0, 2'h0);
    rd_chk(32'h4, 32'h0, 2'h0);
    rd_chk(32'h8, 32'h0, 2'h0);
    rnd = $urandom();
    axi_wr(32'h0, rnd);
    rd_chk(32'h0, {24'h0, rnd[7:0] & 8'h0F}, 2'h0);
    axi_wr(32'h4, 32'hFE);
    rd_chk(32'h4, 32'h7E, 2'h0);
    axi_wr(32'h8, 32'hFF);
    rd_chk(32'h8, 32'h77, 2'h0);
    rd_chk(32'h14, 32'h0, 2'h2);
    axi_wr(32'h0, 32'h0);
    axi_wr(32'h4, 32'h0E);
    axi_wr(32'h8, 32'h07);
    axi_wr(32'hC, 32'h07);
    // pins toggle while both selects are off: no flag may appear
    ext_irq_pin_a <= 1'h1;
    ext_irq_pin_b <= 1'h0;
    tick(8);
    ext_irq_pin_a <= 1'h0;
    ext_irq_pin_b <= 1'h1;
    tick(8);
    rd_chk(32'h4, 32'h0E, 2'h0);
    axi_wr(32'h0, 32'h09);
    ext_irq_pin_a <= 1'h1;
    ext_irq_pin_b <= 1'h0;
    timer_overflow <= 3'h7;
    time_base_overflow <= 2'h1;
    conversion_done <= 1'h1;
    @(posedge core_clk);
    timer_overflow <= 3'h0;
    time_base_overflow <= 2'h0;
    conversion_done <= 1'h0;
    tick(12);
    rd_chk(32'h4, 32'h7E, 2'h0);
    rd_chk(32'h8, 32'h77, 2'h0);
    rd_chk(32'hC, 32'h37, 2'h0);
    c0_exp = 8'h7E;
    for (int i = 0; i < 6; i++) begin
      exp_irq.push_back({1'h1, 8'(4 * (i + 1))});
      axi_wr(32'h4, {24'h0, c0_exp | 8'h01});
      drain();
      if (i < 3) begin
        c0_exp[4 + i] = 1'h0;
      end
    end
    rd_chk(32'h4, {24'h0, c0_exp}, 2'h0);
    rd_chk(32'h8, 32'h07, 2'h0);
    rd_chk(32'hC, 32'h37, 2'h0);
    axi_wr(32'hC, 32'h07);
    rd_chk(32'hC, 32'h07, 2'h0);
    // stack is now full: a forced, enabled timer 0 request must wait
    axi_wr(32'h4, 32'h49);
    tick(40);
    rd_chk(32'h10, 32'h118, 2'h0);
    exp_irq.push_back(9'h10C);
    do_return <= 1'h1;
    @(posedge core_clk);
    do_return <= 1'h0;
    tick(2);
    check("pop", 34'h1, {33'h0, pc_pop});
    drain();
    // both-edge select: either polarity on either pin sets its flag
    axi_wr(32'h4, 32'h00);
    axi_wr(32'h0, 32'h0F);
    ext_irq_pin_a <= 1'h0;
    ext_irq_pin_b <= 1'h1;
    tick(8);
    rd_chk(32'h4, 32'h30, 2'h0);
    axi_wr(32'h4, 32'h00);
    ext_irq_pin_a <= 1'h1;
    ext_irq_pin_b <= 1'h0;
    tick(8);
    rd_chk(32'h4, 32'h30, 2'h0);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    print_verdict();
  end
endmodule : vectored_interrupt_unit_bench
